// *** bench/apo_host.sv ***
`timescale 1ns/100ps
// Host side: times the open-drain line edge to edge, as a capture timer would
module apo_host (
  input  wire logic pin,
  output int        per_ns,
  output int        high_ns,
  output int        low_ns,
  output int        frames
);
  realtime t_rise = 0;
  realtime t_fall = 0;
  // Frame opens on a rise; the released time before the fall is the duty
  initial begin
    per_ns = 0;
    high_ns = 0;
    low_ns = 0;
    frames = 0;
  end
  // First rise has no earlier rise, so no period is reported for it
  always @(posedge pin) begin
    if (t_rise > 0) begin
      per_ns = int'($realtime - t_rise);
      frames = frames + 1;
    end
    // Low time from the fall, back porch included, closes the frame before the next rise
    if (t_fall > 0) begin
      low_ns = int'($realtime - t_fall);
    end
    t_rise = $realtime;
  end
  always @(negedge pin) begin
    high_ns = int'($realtime - t_rise);
    t_fall = $realtime;
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import apo_pkg::*;
  localparam int unsigned HZ = 1000000;
  logic clk = 0, nrst = 0, en = 0, sclk = 0, cs_n = 1, safe, od_o, od_oe, pin;
  logic [2:0]  por_sel = '0;
  logic [3:0]  per_sel = '0;
  logic [15:0] ang_in = '0, red_off = 16'h0010, ang_reg, snap;
  logic [31:0] seed = 32'h9a63;
  logic [15:0] exp_reg = APO_ANGLE_RST;
  int mismatches = 0, cmp_count = 0, cyc = 0, since = 0, per_ns, high_ns, low_ns, frames, bad;
  // Pull-up on the line: only a driven low pulls it down
  assign pin = od_oe ? od_o : 1'b1;
  always #10 clk = ~clk;
  apo_top #(.CLK_HZ(HZ)) u_apo_top (
    .CLK(clk), .NRST(nrst), .PWM_EN(en), .PORCH_SEL(por_sel), .PERIOD_SEL(per_sel),
    .ANGLE_IN(ang_in), .RED_AB(ang_in + red_off), .RED_BC(ang_in - red_off),
    .RED_CA(ang_in + red_off), .MISMATCH_LIMIT(16'h0100), .SCLK(sclk), .CS_N(cs_n),
    .ANGLE_REG(ang_reg), .SNAP_DATA(snap), .SAFE_STATE(safe), .PWM_OUT_O(od_o),
    .PWM_OUT_OE(od_oe));
  apo_host u_apo_host (.pin(pin), .per_ns(per_ns), .high_ns(high_ns), .low_ns(low_ns),
    .frames(frames));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Inputs always move 2 ns after the rising edge
  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Model of one carrier frame; waits out one angle reload so every counted start is fresh
  task automatic pwm_case(input logic [3:0] ps, input logic [2:0] pc, input logic [15:0] a);
    int per, por, hi, f;
    ang_in = a;
    per_sel = ps;
    por_sel = pc;
    en = 1;
    stp(APO_ANG_UPD_CYC + 1);
    f = frames;
    while (frames < f + 2) stp(1);
    per = HZ / APO_FREQ_HZ[ps];
    por = (pc == 3'h7) ? 0 : per * (APO_PORCH_BASE_PCT + pc) / APO_PCT_FULL;
    hi = por + (int'(a) * (per - 2 * por)) / 65536;
    chk(per_ns / APO_CLK_PERIOD_NS, per);
    chk(high_ns / APO_CLK_PERIOD_NS, hi);
    chk(low_ns / APO_CLK_PERIOD_NS, per - hi);
  endtask
  // Register watch: model loads only on the interval grid and holds between loads
  always @(posedge clk) begin
    #1;
    if (nrst) begin
      since++;
      if (since % APO_ANG_UPD_CYC == 0) begin
        exp_reg = ang_in;
        chk(ang_reg, ang_in);
      end
      chk(ang_reg, exp_reg);
    end
  end
  // Hang guard sized well above the longest scenario
  always @(posedge clk) begin
    cyc++;
    if (cyc > 95000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    stp(4);
    nrst = 1;
    chk({snap, safe, od_oe}, 0);
    repeat (500) begin
      seed = lfsr(seed);
      ang_in = seed[15:0];
      stp(1);
    end
    // All porch codes, every carrier, random angles kept clear of a zero duty
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      pwm_case(4'(i), 3'(i % 8), seed[15:0] | 16'h1000);
    end
    pwm_case(4'h7, 3'h6, 16'h0000);
    pwm_case(4'h7, 3'h0, 16'hffff);
    en = 0;
    stp(2);
    bad = 0;
    repeat (60) begin
      stp(1);
      bad += (od_oe !== 1'b0);
    end
    chk(bad, 0);
    cs_n = 0;
    stp(4);
    sclk = 1;
    stp(10);
    chk(snap, 16'hffff);
    ang_in = 16'h1234;
    stp(250);
    sclk = 0;
    stp(10);
    chk(snap, 16'hffff);
    // Chip select high rearms; the next frame takes the fresh register
    cs_n = 1;
    stp(6);
    cs_n = 0;
    stp(4);
    sclk = 1;
    stp(10);
    chk(snap, exp_reg);
    chk(safe, 0);
    red_off = 16'h4000;
    en = 1;
    stp(3);
    chk(safe, 1);
    bad = 0;
    repeat (40) begin
      stp(1);
      bad += (od_oe !== 1'b1);
    end
    chk(bad, 0);
    test_done;
  end
endmodule

// *** core/apo_pkg.sv ***
package apo_pkg;
  // Clock and angle word
  localparam int unsigned APO_CLK_HZ         = 50_000_000;
  localparam int unsigned APO_CLK_PERIOD_NS  = 20;
  localparam int unsigned APO_ANGLE_W        = 16;
  localparam int unsigned APO_CNT_W          = 19;
  // Internal angle register refresh time, no interpolation
  localparam int unsigned APO_ANG_UPD_NS     = 2000;
  localparam int unsigned APO_ANG_UPD_CYC    = APO_ANG_UPD_NS / APO_CLK_PERIOD_NS;
  // Field positions inside extended configuration word 0x3f
  localparam int unsigned APO_CFG_WORD       = 32'h0000003f;
  localparam int unsigned APO_EN_BIT         = 17;
  localparam int unsigned APO_PORCH_MSB      = 13;
  localparam int unsigned APO_PORCH_LSB      = 11;
  localparam int unsigned APO_PERIOD_MSB     = 10;
  localparam int unsigned APO_PERIOD_LSB     = 7;
  // Porch code: 0..6 give 2..8 percent, 7 gives none
  localparam logic [2:0]  APO_PORCH_OFF_CODE = 3'h7;
  localparam int unsigned APO_PORCH_BASE_PCT = 2;
  localparam int unsigned APO_PCT_FULL       = 100;
  // Carrier frequency per period code, Hz
  localparam int unsigned APO_FREQ_HZ [16] = '{125, 167, 250, 333, 500, 667, 800, 1000,
                                               1333, 1600, 2000, 2667, 4000, 5333, 8000,
                                               16000};
  // Reset values
  localparam logic [15:0] APO_ANGLE_RST      = 16'h0000;
endpackage

// *** core/apo_plaus.sv ***
`timescale 1ns/100ps
module apo_plaus
  import apo_pkg::*;
#(
  parameter int unsigned ANGLE_W = APO_ANGLE_W
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [ANGLE_W-1:0] main_ang,
  input  wire logic [ANGLE_W-1:0] red_ang [3],
  input  wire logic [ANGLE_W-1:0] limit,
  output logic                    safe
);

  logic [2:0] over;
  logic       safe_r;

  if (ANGLE_W < 2) begin : g_chk
    $error("apo_plaus: ANGLE_W too small");
  end

  // Shortest distance around the circle, so 359 vs 1 degree is close
  function automatic logic [ANGLE_W-1:0] circ_dist(input logic [ANGLE_W-1:0] a,
                                                   input logic [ANGLE_W-1:0] b);
    logic [ANGLE_W-1:0] d;
    d = a - b;
    circ_dist = d[ANGLE_W-1] ? (~d + 1'b1) : d;
  endfunction

  // One comparator per redundant angle, all checked every cycle
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    assign over[i] = circ_dist(main_ang, red_ang[i]) > limit;
  end

  // Sticky: only reset leaves the safe state, a glitchy path must not recover itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      safe_r <= 1'b0;
    end else if (|over) begin
      safe_r <= 1'b1;
    end
  end

  assign safe = safe_r;

  AST_TRIP: assert property (@(posedge clk) disable iff (!nrst)
    (|over) |=> safe) else $error("mismatch did not trip safe state");
  AST_STICKY: assert property (@(posedge clk) disable iff (!nrst)
    safe |=> safe) else $error("safe state left without reset");
  AST_NO_FALSE: assert property (@(posedge clk) disable iff (!nrst)
    (!safe && !(|over)) |=> !safe) else $error("safe state without mismatch");

endmodule

// *** core/apo_top.sv ***
`timescale 1ns/100ps
module apo_top
  import apo_pkg::*;
#(
  parameter int unsigned CLK_HZ  = APO_CLK_HZ,
  parameter int unsigned ANGLE_W = APO_ANGLE_W,
  parameter int unsigned CNT_W   = APO_CNT_W
) (
  input  wire logic               CLK,
  input  wire logic               NRST,
  input  wire logic               PWM_EN,
  input  wire logic [2:0]         PORCH_SEL,
  input  wire logic [3:0]         PERIOD_SEL,
  input  wire logic [ANGLE_W-1:0] ANGLE_IN,
  input  wire logic [ANGLE_W-1:0] RED_AB,
  input  wire logic [ANGLE_W-1:0] RED_BC,
  input  wire logic [ANGLE_W-1:0] RED_CA,
  input  wire logic [ANGLE_W-1:0] MISMATCH_LIMIT,
  input  wire logic               SCLK,
  input  wire logic               CS_N,
  output logic [ANGLE_W-1:0]      ANGLE_REG,
  output logic [ANGLE_W-1:0]      SNAP_DATA,
  output logic                    SAFE_STATE,
  output logic                    PWM_OUT_O,
  output logic                    PWM_OUT_OE
);

  // Elaboration checks
  if (ANGLE_W < 2 || ANGLE_W > 16) begin : g_chk_ang
    $error("apo_top: ANGLE_W out of range");
  end
  if ((CLK_HZ / APO_FREQ_HZ[0]) >= (64'd1 << CNT_W)) begin : g_chk_cnt
    $error("apo_top: CNT_W too narrow for slowest carrier");
  end

  localparam logic [7:0] UPD_LAST = 8'(APO_ANG_UPD_CYC - 1);

  logic [7:0]           upd_div_r;
  logic                 upd_tick;
  logic [ANGLE_W-1:0]   ang_reg_r;
  logic [ANGLE_W-1:0]   pwm_ang_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     per_r;
  logic [CNT_W-1:0]     porch_r;
  logic                 run_r;
  logic                 start;
  logic [CNT_W-1:0]     per_nxt;
  logic [CNT_W-1:0]     porch_nxt;
  logic [CNT_W-1:0]     span;
  logic [CNT_W+ANGLE_W-1:0] prod;
  logic [CNT_W-1:0]     high_c;
  logic                 oe_r;
  logic                 safe;
  logic [ANGLE_W-1:0]   red_ang [3];
  logic                 sclk_m_r, sclk_s_r, sclk_d_r;
  logic                 cs_m_r, cs_s_r;
  logic                 armed_r;
  logic                 first_edge;
  logic [ANGLE_W-1:0]   snap_r;

  // Carrier period in clocks for a frequency code
  function automatic logic [CNT_W-1:0] period_cycles(input logic [3:0] sel);
    period_cycles = CNT_W'(CLK_HZ / APO_FREQ_HZ[sel]);
  endfunction

  // Porch width in percent for a porch code
  function automatic int unsigned porch_pct(input logic [2:0] sel);
    porch_pct = (sel == APO_PORCH_OFF_CODE) ? 0 : APO_PORCH_BASE_PCT + int'(sel);
  endfunction

  // Update interval divider; one-cycle tick
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      upd_div_r <= 8'h00;
    end else if (upd_div_r == UPD_LAST) begin
      upd_div_r <= 8'h00;
    end else begin
      upd_div_r <= upd_div_r + 8'h01;
    end
  end

  assign upd_tick = (upd_div_r == UPD_LAST);

  // Internal angle register, refreshed each interval
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ang_reg_r <= ANGLE_W'(APO_ANGLE_RST);
    end else if (upd_tick) begin
      ang_reg_r <= ANGLE_IN;
    end
  end

  // Plausibility check on the raw main angle
  assign red_ang[0] = RED_AB;
  assign red_ang[1] = RED_BC;
  assign red_ang[2] = RED_CA;

  apo_plaus #(.ANGLE_W(ANGLE_W)) u_plaus (
    .clk      (CLK),
    .nrst     (NRST),
    .main_ang (ANGLE_IN),
    .red_ang  (red_ang),
    .limit    (MISMATCH_LIMIT),
    .safe     (safe)
  );

  // Period start: first cycle after enable, or wrap of the counter
  assign start     = PWM_EN && (!run_r || cnt_r == per_r - 1'b1);
  assign per_nxt   = period_cycles(PERIOD_SEL);
  assign porch_nxt = CNT_W'((32'(per_nxt) * porch_pct(PORCH_SEL)) / APO_PCT_FULL);

  // Settings and angle are frozen per period so a write cannot tear a pulse
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_r     <= 1'b0;
      cnt_r     <= '0;
      per_r     <= '0;
      porch_r   <= '0;
      pwm_ang_r <= '0;
    end else if (!PWM_EN) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else if (start) begin
      run_r     <= 1'b1;
      cnt_r     <= '0;
      per_r     <= per_nxt;
      porch_r   <= porch_nxt;
      pwm_ang_r <= ang_reg_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // High time: front porch plus angle share of the span between porches
  assign span   = per_r - (porch_r << 1);
  assign prod   = pwm_ang_r * span;
  assign high_c = porch_r + prod[CNT_W+ANGLE_W-1:ANGLE_W];

  // Pin released (high) during the duty part, pulled low for the rest
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      oe_r <= 1'b0;
    end else if (!PWM_EN) begin
      oe_r <= 1'b0;
    end else if (safe) begin
      oe_r <= 1'b1; // Safe state holds the line low, no valid duty
    end else if (run_r) begin
      oe_r <= (cnt_r >= high_c);
    end else begin
      oe_r <= 1'b0;
    end
  end

  assign PWM_OUT_O  = 1'b0;
  assign PWM_OUT_OE = oe_r;

  // Serial pins cross in through two flops each
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      cs_m_r   <= 1'b1;
      cs_s_r   <= 1'b1;
    end else begin
      sclk_m_r <= SCLK;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      cs_m_r   <= CS_N;
      cs_s_r   <= cs_m_r;
    end
  end

  assign first_edge = armed_r && !cs_s_r && (sclk_s_r != sclk_d_r);

  // Snapshot once per frame so later refreshes cannot change the reply
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      armed_r <= 1'b1;
      snap_r  <= '0;
    end else if (cs_s_r) begin
      armed_r <= 1'b1;
    end else if (first_edge) begin
      armed_r <= 1'b0;
      snap_r  <= ang_reg_r;
    end
  end

  assign ANGLE_REG  = ang_reg_r;
  assign SNAP_DATA  = snap_r;
  assign SAFE_STATE = safe;

  AST_OFF_RELEASED: assert property (@(posedge CLK) disable iff (!NRST)
    !PWM_EN |=> !PWM_OUT_OE) else $error("line driven while disabled");
  AST_NO_RUN_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    !PWM_EN |=> !run_r && cnt_r == 0) else $error("carrier running while disabled");
  AST_ANGLE_LATCH: assert property (@(posedge CLK) disable iff (!NRST)
    start |=> pwm_ang_r == $past(ang_reg_r)) else $error("angle not captured at start");
  AST_ANGLE_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    (run_r && !start && PWM_EN) |=> $stable(pwm_ang_r)) else $error("angle changed mid period");
  AST_REG_UPDATE: assert property (@(posedge CLK) disable iff (!NRST)
    upd_tick |=> ang_reg_r == $past(ANGLE_IN) ##1 !upd_tick [*8])
    else $error("angle register update wrong");
  AST_DUTY_HIGH: assert property (@(posedge CLK) disable iff (!NRST)
    (PWM_EN && run_r && !safe && cnt_r < high_c) |=> !PWM_OUT_OE)
    else $error("line low during duty time");
  AST_DUTY_LOW: assert property (@(posedge CLK) disable iff (!NRST)
    (PWM_EN && run_r && !safe && cnt_r >= high_c) |=> PWM_OUT_OE)
    else $error("line released after duty time");
  AST_PORCH_BOUNDS: assert property (@(posedge CLK) disable iff (!NRST)
    run_r |-> (high_c >= porch_r) && (high_c <= per_r - porch_r))
    else $error("high time outside porches");
  AST_PORCH_WIDTH: assert property (@(posedge CLK) disable iff (!NRST)
    start && PORCH_SEL == APO_PORCH_OFF_CODE |=> porch_r == 0)
    else $error("porch code 7 not zero");
  AST_PERIOD_WRAP: assert property (@(posedge CLK) disable iff (!NRST)
    start |=> per_r == $past(per_nxt) && cnt_r == 0) else $error("period not reloaded");
  AST_SAFE_LOW: assert property (@(posedge CLK) disable iff (!NRST)
    (PWM_EN && safe) |=> PWM_OUT_OE) else $error("safe state not forcing line low");
  AST_SNAP_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    (!first_edge) |=> $stable(snap_r)) else $error("snapshot changed inside frame");

  COV_PERIOD: cover property (@(posedge CLK) disable iff (!NRST) start ##1 !start [*3]);
  COV_SAFE: cover property (@(posedge CLK) disable iff (!NRST) $rose(safe));
  COV_SNAP: cover property (@(posedge CLK) disable iff (!NRST) first_edge);
  COV_REFRESH_MID: cover property (@(posedge CLK) disable iff (!NRST) run_r && upd_tick);

endmodule
